// [design/prescaled_timer_counter.v]
// Prescaled 8/16-bit timer/counter with overflow flag and buffered
// high byte. Assumes a register port in the clock domain, a count pin
// asynchronous to clk_i, and an instruction-cycle enable from outside.
`timescale 1ns/1ns
`include "prescaled_timer_consts.vh"

// What this block does
// - Control bit 7 set lets the counter run; cleared halts it.
// - Control bit 6 set gives 8-bit width; cleared gives 16-bit.
// - Control bit 5 set counts pin edges; cleared counts cycles.
// - Control bit 4 set counts falling pin edges; cleared rising.
// - Control bit 3 set bypasses the prescaler; cleared uses it.
// - Ratio code 000 divides by 2, each step doubles, 111 by 256.
// - Internal clock, no prescaler: count once per instruction cycle.
// - Any counter write holds off counting for two instruction cycles.
// - External pin is synchronised before counting, adding delay.
// - Prescaler is an 8-bit counter hidden from software.
// - Counter write clears the prescaler count, keeps its settings.
// - Prescaler assignment may change while running, no stop needed.
// - Overflow flag sets on wrap FFh->00h or FFFFh->0000h.
// - Cleared enable masks the request; flag still records wraps.
// - Sleep stops the counter, so no overflow can wake the core.
// - 16-bit mode: low-byte read copies true high byte to buffer.
// - 16-bit mode: low-byte write loads high byte from buffer.
// - 16-bit mode: true high byte reachable only via buffer.
module prescaled_timer_counter #(
   parameter PRESCALE_WIDTH = 8
) (
   input  wire       clk_i,
   input  wire       rst_b_i,
   input  wire       cycle_en_i,
   input  wire       sleep_i,
   input  wire       count_pin_i,
   input  wire [1:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   output wire       overflow_irq_o
);

   // ===================================================================
   // Registers and state
   reg  [7:0]                timer_control;
   reg  [7:0]                counter_high_buffer;
   reg  [7:0]                int_other;
   reg                       overflow_flag;
   reg  [15:0]               counter;
   reg  [PRESCALE_WIDTH-1:0] prescale_count;
   reg  [1:0]                hold_count;
   reg                       pin_sync1;
   reg                       pin_sync2;
   reg                       pin_prev;

   wire run_control      = timer_control[`BIT_RUN_CONTROL];
   wire width_select     = timer_control[`BIT_WIDTH_SELECT];
   wire source_select    = timer_control[`BIT_SOURCE_SELECT];
   wire edge_select      = timer_control[`BIT_EDGE_SELECT];
   wire prescaler_bypass = timer_control[`BIT_PRESCALER_BYPASS];
   wire [2:0] prescale_ratio =
      timer_control[`RATIO_MSB:`RATIO_LSB];
   wire overflow_enable  = int_other[`BIT_OVERFLOW_ENABLE];

   // ===================================================================
   // Register decode
   // Register select, shared by every strobe decode
   function addr_hit;
      input       strobe;
      input [1:0] addr;
      input [1:0] target;
      begin
         addr_hit = strobe && (addr == target);
      end
   endfunction

   wire wr_low  = addr_hit(wr_i, addr_i, `ADDR_COUNTER_LOW);
   wire wr_high = addr_hit(wr_i, addr_i, `ADDR_COUNTER_HIGH);
   wire wr_int  = addr_hit(wr_i, addr_i, `ADDR_INT_CONTROL);
   wire wr_ctl  = addr_hit(wr_i, addr_i, `ADDR_TIMER_CONTROL);
   wire rd_low  = addr_hit(rd_i, addr_i, `ADDR_COUNTER_LOW);

   // An 8-bit mode write to the high address is treated as a counter
   // write as well, so both clear the prescaler and start the hold
   wire counter_write = wr_low || (wr_high && width_select);

   // ===================================================================
   // Clock source selection
   // Pin edges only ever looked at on the second synchroniser stage
   // synchronised pin edge
   wire pin_rise = pin_sync2 & ~pin_prev;
   wire pin_fall = ~pin_sync2 & pin_prev;

   wire ext_tick = edge_select ? pin_fall : pin_rise;
   wire src_tick = source_select ? ext_tick : cycle_en_i;

   wire active = run_control & ~sleep_i;

   // ===================================================================
   // Prescaler
   // Returns the prescaler bit whose rising toggle marks a ratio period
   function [PRESCALE_WIDTH-1:0] ratio_mask;
      input [2:0] code;
      begin
         ratio_mask = {PRESCALE_WIDTH{1'b0}};
         ratio_mask[code] = 1'b1;
      end
   endfunction

   // terminal when the ratio bit and all bits below it are set
   wire [PRESCALE_WIDTH-1:0] mask = ratio_mask(prescale_ratio);
   // Mask with all bits up to the ratio bit; no shift, so nothing is
   // lost off the top at the widest ratio
   wire [PRESCALE_WIDTH-1:0] low_bits = mask | (mask - 1'b1);
   wire pre_tick = ((prescale_count & low_bits) == low_bits);

   wire count_tick_raw = prescaler_bypass ? src_tick
                                          : (src_tick & pre_tick);

   wire count_tick = active & count_tick_raw & (hold_count == 2'h0);

   // ===================================================================
   // Counter and overflow
   wire [15:0] count_plus_one = counter + 16'h0001;

   wire wrap = width_select ? (counter[7:0] == 8'hFF)
                            : (counter == 16'hFFFF);

   // ===================================================================
   // Next-state values
   reg  [PRESCALE_WIDTH-1:0] next_prescale_count;
   reg  [1:0]                next_hold_count;
   reg  [15:0]               next_counter;
   reg  [7:0]                next_high_buffer;
   reg  [7:0]                next_timer_control;
   reg  [7:0]                next_int_other;
   reg                       next_overflow_flag;
   reg  [7:0]                next_rdata;

   // ===================================================================
   // Pin synchroniser
   // Only the second stage feeds the edge detector; the first stage
   // may still be settling and is read by nothing else
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_sync1 <= 1'b0;
         pin_sync2 <= 1'b0;
         pin_prev  <= 1'b0;
      end else begin
         pin_sync1 <= count_pin_i;
         pin_sync2 <= pin_sync1;
         pin_prev  <= pin_sync2;
      end
   end

   // ===================================================================
   // Prescaler update
   always @* begin
      next_prescale_count = prescale_count;
      if (counter_write) begin
         next_prescale_count = {PRESCALE_WIDTH{1'b0}};
      end else if (active && src_tick && !prescaler_bypass) begin
         next_prescale_count = prescale_count + 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         prescale_count <= {PRESCALE_WIDTH{1'b0}};
      end else begin
         prescale_count <= next_prescale_count;
      end
   end

   // ===================================================================
   // Write hold
   // Counts instruction cycles, not clocks, so the hold length tracks
   // the instruction rate whatever the source or prescaler setting
   always @* begin
      next_hold_count = hold_count;
      if (counter_write) begin
         next_hold_count = `WRITE_HOLD_CYCLES;
      end else if (cycle_en_i && (hold_count != 2'h0)) begin
         next_hold_count = hold_count - 2'h1;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         hold_count <= 2'h0;
      end else begin
         hold_count <= next_hold_count;
      end
   end

   // ===================================================================
   // Counter update
   // A write wins over a tick in the same cycle: the written value is
   // what software expects to see, and the hold follows it anyway
   always @* begin
      next_counter = counter;
      if (wr_low) begin
         next_counter[7:0] = wdata_i;
         if (!width_select) begin
            next_counter[15:8] = counter_high_buffer;
         end
      end else if (count_tick) begin
         if (width_select) begin
            next_counter[7:0] = count_plus_one[7:0];
         end else begin
            next_counter = count_plus_one;
         end
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         counter <= `RST_COUNTER;
      end else begin
         counter <= next_counter;
      end
   end

   // ===================================================================
   // High byte buffer
   always @* begin
      next_high_buffer = counter_high_buffer;
      if (wr_high) begin
         next_high_buffer = wdata_i;
      // latch high byte on low read
      end else if (rd_low && !width_select) begin
         next_high_buffer = counter[15:8];
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         counter_high_buffer <= `RST_COUNTER_HIGH;
      end else begin
         counter_high_buffer <= next_high_buffer;
      end
   end

   // ===================================================================
   // Control registers
   always @* begin
      next_timer_control = timer_control;
      next_int_other     = int_other;
      if (wr_ctl) begin
         next_timer_control = wdata_i;
      end
      if (wr_int) begin
         next_int_other = wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         timer_control <= `RST_TIMER_CONTROL;
         int_other     <= `RST_INT_CONTROL;
      end else begin
         timer_control <= next_timer_control;
         int_other     <= next_int_other;
      end
   end

   // ===================================================================
   // Overflow flag
   // Set beats a software clear in the same cycle, so a wrap is never
   // lost; the cost is that a clear may need repeating
   always @* begin
      next_overflow_flag = overflow_flag;
      if (count_tick && wrap) begin
         next_overflow_flag = 1'b1;
      end else if (wr_int) begin
         next_overflow_flag = wdata_i[`BIT_OVERFLOW_FLAG];
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         overflow_flag <= 1'b0;
      end else begin
         overflow_flag <= next_overflow_flag;
      end
   end

   assign overflow_irq_o = overflow_flag & overflow_enable;

   // ===================================================================
   // Read port
   // Data stands for one cycle only and is zero otherwise, so a stale
   // value can never be mistaken for a fresh read
   // high address returns buffer in 16-bit mode, true high byte in 8-bit mode
   always @* begin
      next_rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `ADDR_COUNTER_LOW: begin
               next_rdata = counter[7:0];
            end
            `ADDR_COUNTER_HIGH: begin
               if (width_select) begin
                  next_rdata = counter[15:8];
               end else begin
                  next_rdata = counter_high_buffer;
               end
            end
            `ADDR_INT_CONTROL: begin
               next_rdata = {int_other[7:3],
                             overflow_flag,
                             int_other[1:0]};
            end
            `ADDR_TIMER_CONTROL: begin
               next_rdata = timer_control;
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= next_rdata;
      end
   end

endmodule

// [include/prescaled_timer_consts.vh]
// Register offsets, field positions, reset values and timing counts
// for the prescaled timer/counter. Definitions only.
`ifndef PRESCALED_TIMER_CONSTS_VH
`define PRESCALED_TIMER_CONSTS_VH

// ======================================================================
// Register offsets
`define ADDR_COUNTER_LOW     2'h0
`define ADDR_COUNTER_HIGH    2'h1
`define ADDR_INT_CONTROL     2'h2
`define ADDR_TIMER_CONTROL   2'h3

// ======================================================================
// Timer control fields
`define BIT_RUN_CONTROL      7
`define BIT_WIDTH_SELECT     6
`define BIT_SOURCE_SELECT    5
`define BIT_EDGE_SELECT      4
`define BIT_PRESCALER_BYPASS 3
`define RATIO_MSB            2
`define RATIO_LSB            0

// ======================================================================
// Interrupt control fields
`define BIT_OVERFLOW_ENABLE  5
`define BIT_OVERFLOW_FLAG    2

// ======================================================================
// Reset values
`define RST_TIMER_CONTROL    8'hFF
`define RST_COUNTER_HIGH     8'h00
`define RST_INT_CONTROL      8'h00
`define RST_COUNTER          16'h0000

// ======================================================================
// Timing
`define WRITE_HOLD_CYCLES    2'h2

`endif

// [dv/prescaled_timer_counter_props.sv]
// Port checker for the prescaled timer/counter.
// Assumes one clock and the synchronous active-low reset of the block.
`timescale 1ns/1ns
// ==================================================================
// Checker
module prescaled_timer_counter_props #(
   parameter PRESCALE_WIDTH = 8
) (
   input wire       clk_i,
   input wire       rst_b_i,
   input wire       cycle_en_i,
   input wire       sleep_i,
   input wire       count_pin_i,
   input wire [1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire       wr_i,
   input wire       rd_i,
   input wire [7:0] rdata_o,
   input wire       overflow_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   irq_fall_a: assert property ($fell(overflow_irq_o) |->
      $past(wr_i && addr_i == 2'h2)) else $error("flag cleared by itself");
   sleep_irq_a: assert property ($rose(overflow_irq_o) &&
      $past(sleep_i) |-> $past(wr_i)) else $error("overflow in sleep");
   ctrl_back_a: assert property (wr_i && addr_i == 2'h3 ##1 !wr_i
      ##1 rd_i && addr_i == 2'h3 |=> rdata_o == $past(wdata_i, 3))
      else $error("control readback wrong");
   en_back_a: assert property (wr_i && addr_i == 2'h2 ##1 !wr_i
      ##1 rd_i && addr_i == 2'h2 |=> rdata_o[5] == $past(wdata_i[5], 3))
      else $error("enable readback wrong");
   mask_irq_a: assert property (wr_i && addr_i == 2'h2 &&
      !wdata_i[5] |=> !overflow_irq_o) else $error("masked request seen");
   irq_bits_a: assert property ($past(overflow_irq_o) &&
      $past(rd_i && addr_i == 2'h2) |-> rdata_o[5] && rdata_o[2])
      else $error("request without flag and enable");
   write_hold_a: assert property (wr_i && addr_i == 2'h0 ##1 !wr_i
      ##1 rd_i && addr_i == 2'h0 |=> rdata_o == $past(wdata_i, 3))
      else $error("counter moved during write hold");
endmodule

bind prescaled_timer_counter prescaled_timer_counter_props #(
   .PRESCALE_WIDTH(PRESCALE_WIDTH)) props_u (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .cycle_en_i(cycle_en_i), .sleep_i(sleep_i),
   .count_pin_i(count_pin_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .overflow_irq_o(overflow_irq_o));

// [dv/prescaled_timer_counter_bench.sv]
// Self-checking bench for the prescaled timer/counter.
// Assumes the register port answers one cycle after the read strobe.
`timescale 1ns/1ns
// ==================================================================
// Bench
module prescaled_timer_counter_bench;
   logic       clk_i = 0, rst_b_i = 0, cycle_en_i = 0, sleep_i = 0;
   logic       count_pin_i = 0, wr_i = 0, rd_i = 0;
   logic [1:0] addr_i = 0;
   logic [7:0] wdata_i = 0, v;
   wire  [7:0] rdata_o;
   wire        overflow_irq_o;
   int         n_mismatch = 0, cmp_count = 0;
   always #5 clk_i = ~clk_i;
   prescaled_timer_counter dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .cycle_en_i(cycle_en_i), .sleep_i(sleep_i),
      .count_pin_i(count_pin_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .overflow_irq_o(overflow_irq_o));
   task chk(input [7:0] got, input [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input [1:0] a, input [7:0] d);
      @(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge clk_i) wr_i <= 0;
   endtask
   task rd(input [1:0] a, output [7:0] q);
      @(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
      @(posedge clk_i) rd_i <= 0;
      @(negedge clk_i) q = rdata_o;
   endtask
   task rdc(input [1:0] a, input [7:0] exp);
      rd(a, v);
      chk(v, exp);
   endtask
   task irq(input b);
      @(negedge clk_i) chk({7'h0, overflow_irq_o}, {7'h0, b});
   endtask
   // Pulses are two cycles apart, like a slow instruction clock
   task pulse(input int n);
      repeat (n) begin
         @(posedge clk_i) cycle_en_i <= 1;
         @(posedge clk_i) cycle_en_i <= 0;
      end
   endtask
   task t_count;
      wr(3, 8'hC8); rdc(3, 8'hC8);
      wr(0, 8'hFE); pulse(4);
      rdc(0, 8'h00); rdc(2, 8'h04); irq(0);
      wr(2, 8'h24); irq(1); rdc(2, 8'h24);
      wr(2, 8'h20); irq(0); rdc(2, 8'h20);
      $display("count and flag test done");
   endtask
   // Reads a phase-free rate, since the prescaler phase is hidden
   task t_presc;
      for (int i = 0; i < 8; i++) begin
         wr(3, 8'hC0 + i[7:0]); wr(0, 8'h00); pulse(2);
         rd(0, v); pulse(4 << i); rdc(0, v + 8'h02);
      end
      // Ratio 1:4 from a cleared prescaler: fourth pulse gives one count
      wr(3, 8'hC1); wr(0, 8'h00); pulse(3); rdc(0, 8'h00);
      pulse(1); rdc(0, 8'h01);
      wr(3, 8'hC8); pulse(1); rdc(0, 8'h02);
      $display("prescaler test done");
   endtask
   task ext(input [7:0] c);
      wr(3, c); wr(0, 8'h00); pulse(2);
      repeat (3) begin
         @(posedge clk_i) count_pin_i <= ~count_pin_i;
         repeat (6) @(posedge clk_i);
      end
      rdc(0, 8'h02);
   endtask
   task t_stop;
      wr(3, 8'h48); wr(0, 8'h55); rdc(0, 8'h55); pulse(3);
      rdc(0, 8'h55); wr(3, 8'hC8); sleep_i <= 1; pulse(3);
      rdc(0, 8'h55); wr(2, 8'h24); irq(1);
      wr(2, 8'h00); sleep_i <= 0;
      $display("halt and sleep test done");
   endtask
   task t_wide;
      wr(3, 8'h88); wr(1, 8'h12); wr(0, 8'hFF); pulse(3);
      rdc(0, 8'h00); rdc(1, 8'h13);
      wr(1, 8'hFF); wr(0, 8'hFF); pulse(3); rdc(2, 8'h04);
      rdc(0, 8'h00); rdc(1, 8'h00);
      $display("wide mode test done");
   endtask
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1;
      rdc(3, 8'hFF); rdc(1, 8'h00); rdc(2, 8'h00); rdc(0, 8'h00);
      $display("reset test done");
      t_count();
      t_presc();
      ext(8'hE8);
      ext(8'hF8);
      $display("pin edge test done");
      t_stop();
      t_wide();
      wrap_up();
   end
endmodule
